//--- rtl/flash_host_ctl.sv
// Summary of operation
// - One-time program: write C0H first, then data at target address.
// - Bit 4 flags OTP data error; error bits accumulate until cleared.
// - After last OTP program, write FFH to return to read-array.
// - Any error flag set: issue clear-status before retrying anything; the controller refuses only two-step and OTP ops while an error is pending.
// - After an abort the host repeats the whole command sequence.
// - Only the selected device drives outputs; output enable is shared.
// - Mask reserved bit 0 when polling status.
// - After clear-lock-bits, write FFH to return to read-array.
module flash_host_ctl #(
	parameter int ADDR_W = 20,
	parameter int HIST_DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic [ADDR_W-1:0] addr_o,
	output logic [7:0] dq_o,
	input wire logic [7:0] dq_i,
	output logic dq_oe_n_o,
	output logic ce_n_o,
	output logic oe_n_o,
	output logic we_n_o,
	output logic reset_powerdown_n_o,
	output logic wp_n_o,
	input wire logic ready_busy_n_i
);

	localparam int HW = $clog2(HIST_DEPTH);

	if (ADDR_W < 1 || ADDR_W > 30) begin : g_chk_addr
		$error("ADDR_W must be 1 to 30");
	end
	if (HIST_DEPTH < 2 || (1 << HW) != HIST_DEPTH) begin : g_chk_hist
		$error("HIST_DEPTH must be a power of two, at least 2");
	end

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_SETUP = 3'b001,
		S_PULSE = 3'b011,
		S_RECOVER = 3'b010,
		S_RST = 3'b110,
		S_RST_WAIT = 3'b111
	} state_t;

	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : lane_merge

	// Bus slave
	logic wr_en, rd_en;
	logic [7:0] ctrl_q;
	logic [31:0] addr_reg_q, wdata_q;
	logic [HW-1:0] hist_rptr_q, hist_wptr_q;
	logic [HW:0] hist_cnt_q;
	logic [7:0] hist_rdata;
	logic go;

	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
	assign go = wr_en && wb_adr_i == flash_host_pkg::ADR_CONTROL && wb_sel_i[0] && wb_dat_i[flash_host_pkg::CTL_GO];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= flash_host_pkg::CTL_RESET;
			addr_reg_q <= '0;
			wdata_q <= '0;
			hist_rptr_q <= '0;
		end else if (wr_en) begin
			unique case (wb_adr_i)
				flash_host_pkg::ADR_CONTROL: begin
					if (wb_sel_i[0]) begin
						ctrl_q <= wb_dat_i[7:0] & ~(8'h01 << flash_host_pkg::CTL_GO)
							& ~(8'h01 << flash_host_pkg::CTL_CLR_REFUSED);
					end
				end
				flash_host_pkg::ADR_ADDRESS: addr_reg_q <= lane_merge(addr_reg_q, wb_dat_i, wb_sel_i);
				flash_host_pkg::ADR_WDATA: wdata_q <= lane_merge(wdata_q, wb_dat_i, wb_sel_i);
				flash_host_pkg::ADR_HIST: begin
					if (wb_sel_i[0]) begin
						hist_rptr_q <= wb_dat_i[HW-1:0];
					end
				end
				default: ;
			endcase
		end
	end

	// Ready/busy pin, three-stage synchroniser
	logic rb_s1_q, rb_s2_q, rb_s3_q, rb_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rb_s1_q <= 1'b1;
			rb_s2_q <= 1'b1;
			rb_s3_q <= 1'b1;
			rb_q <= 1'b1;
		end else begin
			rb_s1_q <= ready_busy_n_i;
			rb_s2_q <= rb_s1_q;
			rb_s3_q <= rb_s2_q;
			if (rb_s2_q == rb_s3_q) begin
				rb_q <= rb_s3_q;
			end
		end
	end

	// Sequencer
	state_t state_q;
	flash_host_pkg::op_t op_q, op_req;
	logic [1:0] step_q;
	logic cyc_write_q;
	logic [15:0] cnt_q;
	logic [7:0] rdata_q, status_q;
	logic err_pend_q, refused_q, aborted_q, hist_we, auto_ff_q;
	logic refuse;

	assign op_req = flash_host_pkg::op_t'(wb_dat_i[flash_host_pkg::CTL_OP_LSB +: 3]);
	assign refuse = go && (state_q != S_IDLE || (err_pend_q
		&& (op_req == flash_host_pkg::OP_TWO_STEP || op_req == flash_host_pkg::OP_OTP)));
	assign hist_we = state_q == S_RECOVER && cnt_q == '0 && op_q == flash_host_pkg::OP_POLL
		&& !cyc_write_q && rdata_q[flash_host_pkg::SR_READY];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= S_IDLE;
			op_q <= flash_host_pkg::OP_WRITE;
			step_q <= '0;
			cyc_write_q <= 1'b0;
			cnt_q <= '0;
			addr_o <= '0;
			dq_o <= '0;
			dq_oe_n_o <= 1'b1;
			ce_n_o <= 1'b1;
			oe_n_o <= 1'b1;
			we_n_o <= 1'b1;
			reset_powerdown_n_o <= 1'b1;
			auto_ff_q <= 1'b0;
			rdata_q <= '0;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (go && !refuse) begin
						op_q <= op_req;
						auto_ff_q <= wb_dat_i[flash_host_pkg::CTL_AUTO_FF];
						step_q <= '0;
						addr_o <= addr_reg_q[ADDR_W-1:0];
						cnt_q <= 16'(flash_host_pkg::C_SETUP - 1);
						unique case (op_req)
							flash_host_pkg::OP_READ: begin
								cyc_write_q <= 1'b0;
								ce_n_o <= 1'b0;
								state_q <= S_SETUP;
							end
							flash_host_pkg::OP_RESET: begin
								reset_powerdown_n_o <= 1'b0;
								cnt_q <= 16'(flash_host_pkg::C_RESET - 1);
								state_q <= S_RST;
							end
							default: begin
								cyc_write_q <= 1'b1;
								ce_n_o <= 1'b0;
								dq_oe_n_o <= 1'b0;
								state_q <= S_SETUP;
								unique case (op_req)
									flash_host_pkg::OP_POLL: dq_o <= flash_host_pkg::CMD_READ_STATUS;
									flash_host_pkg::OP_OTP: dq_o <= flash_host_pkg::CMD_OTP_SETUP;
									flash_host_pkg::OP_TWO_STEP: dq_o <= wdata_q[flash_host_pkg::WDATA_SETUP_LSB +: 8];
									default: dq_o <= wdata_q[7:0];
								endcase
							end
						endcase
					end
				end
				S_SETUP: begin
					if (cnt_q == '0) begin
						we_n_o <= !cyc_write_q;
						oe_n_o <= cyc_write_q;
						cnt_q <= cyc_write_q ? 16'(flash_host_pkg::C_STROBE - 1) : 16'(flash_host_pkg::C_ACCESS - 1);
						state_q <= S_PULSE;
					end else begin
						cnt_q <= cnt_q - 16'd1;
					end
				end
				S_PULSE: begin
					if (cnt_q == '0) begin
						if (!cyc_write_q) begin
							rdata_q <= dq_i;
						end
						we_n_o <= 1'b1;
						oe_n_o <= 1'b1;
						ce_n_o <= 1'b1;
						cnt_q <= 16'(flash_host_pkg::C_RECOVER - 1);
						state_q <= S_RECOVER;
					end else begin
						cnt_q <= cnt_q - 16'd1;
					end
				end
				S_RECOVER: begin
					if (cnt_q != '0) begin
						cnt_q <= cnt_q - 16'd1;
					end else begin
						dq_oe_n_o <= 1'b1;
						cnt_q <= 16'(flash_host_pkg::C_SETUP - 1);
						step_q <= step_q + 2'd1;
						state_q <= S_IDLE;
						unique case (op_q)
							flash_host_pkg::OP_TWO_STEP, flash_host_pkg::OP_OTP: begin
								if (step_q == 2'd0) begin
									dq_o <= wdata_q[7:0];
									dq_oe_n_o <= 1'b0;
									ce_n_o <= 1'b0;
									state_q <= S_SETUP;
								end
							end
							flash_host_pkg::OP_POLL: begin
								if (cyc_write_q && step_q == 2'd0) begin
									cyc_write_q <= 1'b0;
									ce_n_o <= 1'b0;
									state_q <= S_SETUP;
								end else if (!cyc_write_q && !rdata_q[flash_host_pkg::SR_READY]) begin
									step_q <= step_q;
									ce_n_o <= 1'b0;
									state_q <= S_SETUP;
								end else if (!cyc_write_q && auto_ff_q) begin
									cyc_write_q <= 1'b1;
									dq_o <= flash_host_pkg::CMD_READ_ARRAY;
									dq_oe_n_o <= 1'b0;
									ce_n_o <= 1'b0;
									state_q <= S_SETUP;
								end
							end
							default: ;
						endcase
					end
				end
				S_RST: begin
					if (cnt_q == '0) begin
						reset_powerdown_n_o <= 1'b1;
						cnt_q <= 16'(flash_host_pkg::C_RESET_REC - 1);
						state_q <= S_RST_WAIT;
					end else begin
						cnt_q <= cnt_q - 16'd1;
					end
				end
				S_RST_WAIT: begin
					if (cnt_q != '0) begin
						cnt_q <= cnt_q - 16'd1;
					end else if (rb_q) begin
						state_q <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// Status copy and error tracking
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_q <= '0;
			err_pend_q <= 1'b0;
			aborted_q <= 1'b0;
		end else if (hist_we) begin
			status_q <= rdata_q & flash_host_pkg::SR_POLL_MASK;
			err_pend_q <= err_pend_q || |(rdata_q & flash_host_pkg::SR_ERR_MASK);
		end else if (state_q == S_RST && cnt_q == '0) begin
			status_q <= '0;
			err_pend_q <= 1'b0;
			aborted_q <= !rb_q;
		end else if (state_q == S_RECOVER && cnt_q == '0 && op_q == flash_host_pkg::OP_CLEAR) begin
			err_pend_q <= 1'b0;
			status_q <= status_q & ~flash_host_pkg::SR_ERR_MASK;
		end else if (go && !refuse && op_req != flash_host_pkg::OP_RESET) begin
			aborted_q <= 1'b0;
		end
	end

	// Refusal flag, a new refusal wins over the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			refused_q <= 1'b0;
		end else if (refuse) begin
			refused_q <= 1'b1;
		end else if (wr_en && wb_adr_i == flash_host_pkg::ADR_CONTROL && wb_sel_i[0]
				&& wb_dat_i[flash_host_pkg::CTL_CLR_REFUSED]) begin
			refused_q <= 1'b0;
		end
	end

	// History of completed status polls
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hist_wptr_q <= '0;
			hist_cnt_q <= '0;
		end else if (hist_we) begin
			hist_wptr_q <= hist_wptr_q + 1'b1;
			if (hist_cnt_q != (HW + 1)'(HIST_DEPTH)) begin
				hist_cnt_q <= hist_cnt_q + 1'b1;
			end
		end
	end

	status_hist_mem #(
		.WIDTH(8),
		.DEPTH(HIST_DEPTH)
	) u_hist (
		.clk_i(clk_i),
		.we_i(hist_we),
		.waddr_i(hist_wptr_q),
		.wdata_i(rdata_q & flash_host_pkg::SR_POLL_MASK),
		.raddr_i(hist_rptr_q),
		.rdata_o(hist_rdata)
	);

	assign wp_n_o = ctrl_q[flash_host_pkg::CTL_WP];

	// Read mux; reads have no side effects
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (rd_en) begin
			unique case (wb_adr_i)
				flash_host_pkg::ADR_CONTROL: wb_dat_o <= {24'h000000, ctrl_q};
				flash_host_pkg::ADR_ADDRESS: wb_dat_o <= addr_reg_q;
				flash_host_pkg::ADR_WDATA: wb_dat_o <= wdata_q;
				flash_host_pkg::ADR_STATUS: begin
					wb_dat_o <= '0;
					wb_dat_o[7:0] <= status_q;
					wb_dat_o[flash_host_pkg::ST_BUSY] <= state_q != S_IDLE;
					wb_dat_o[flash_host_pkg::ST_RB] <= rb_q;
					wb_dat_o[flash_host_pkg::ST_ERR_PEND] <= err_pend_q;
					wb_dat_o[flash_host_pkg::ST_REFUSED] <= refused_q;
					// both bits mark a sequence error
					wb_dat_o[flash_host_pkg::ST_SEQ_ERR] <= status_q[flash_host_pkg::SR_ERASE_ERR]
						&& status_q[flash_host_pkg::SR_WRITE_ERR];
					wb_dat_o[flash_host_pkg::ST_ABORTED] <= aborted_q;
				end
				flash_host_pkg::ADR_RDATA: wb_dat_o <= {24'h000000, rdata_q};
				flash_host_pkg::ADR_HIST: wb_dat_o <= {16'h0000, 7'(hist_cnt_q), 1'b0, hist_rdata};
				default: wb_dat_o <= '0;
			endcase
		end
	end

endmodule : flash_host_ctl

//--- rtl/flash_host_pkg.sv
package flash_host_pkg;

	localparam int CLK_MHZ = 20;

	// Register byte offsets
	localparam logic [7:0] ADR_CONTROL = 8'h00;
	localparam logic [7:0] ADR_ADDRESS = 8'h04;
	localparam logic [7:0] ADR_WDATA = 8'h08;
	localparam logic [7:0] ADR_STATUS = 8'h0c;
	localparam logic [7:0] ADR_RDATA = 8'h10;
	localparam logic [7:0] ADR_HIST = 8'h14;

	// Control register fields
	localparam int CTL_OP_LSB = 0;
	localparam int CTL_GO = 3;
	localparam int CTL_WP = 4;
	localparam int CTL_AUTO_FF = 5;
	localparam int CTL_CLR_REFUSED = 7;
	localparam logic [7:0] CTL_RESET = 8'h10;

	// Status register fields of this controller, then the setup byte position in the write data register
	localparam int ST_BUSY = 8;
	localparam int ST_RB = 9;
	localparam int ST_ERR_PEND = 10;
	localparam int ST_REFUSED = 11;
	localparam int ST_SEQ_ERR = 12;
	localparam int ST_ABORTED = 13;
	localparam int WDATA_SETUP_LSB = 8;

	// Device status byte fields
	localparam int SR_READY = 7;
	localparam int SR_ERASE_ERR = 5;
	localparam int SR_WRITE_ERR = 4;
	localparam int SR_SUPPLY_ERR = 3;
	localparam int SR_PROTECT = 1;
	localparam logic [7:0] SR_POLL_MASK = 8'hfe;
	localparam logic [7:0] SR_ERR_MASK = 8'h3a;

	// Device command codes
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_OTP_SETUP = 8'hc0;

	typedef enum logic [2:0] {
		OP_WRITE = 3'h0,
		OP_READ = 3'h1,
		OP_TWO_STEP = 3'h2,
		OP_POLL = 3'h3,
		OP_RESET = 3'h4,
		OP_CLEAR = 3'h5,
		OP_OTP = 3'h6
	} op_t;

	// Pin timing, least times in ns
	localparam int T_SETUP_NS = 50;
	localparam int T_STROBE_NS = 100;
	localparam int T_ACCESS_NS = 150;
	localparam int T_RECOVER_NS = 50;
	localparam int T_RESET_NS = 150;
	localparam int T_RESET_REC_NS = 1000;

	function automatic int cycles_min(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : cycles_min

	localparam int C_SETUP = cycles_min(T_SETUP_NS);
	localparam int C_STROBE = cycles_min(T_STROBE_NS);
	localparam int C_ACCESS = cycles_min(T_ACCESS_NS);
	localparam int C_RECOVER = cycles_min(T_RECOVER_NS);
	localparam int C_RESET = cycles_min(T_RESET_NS);
	localparam int C_RESET_REC = cycles_min(T_RESET_REC_NS);

endpackage : flash_host_pkg

//--- rtl/status_hist_mem.sv
module status_hist_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [$clog2(DEPTH)-1:0] waddr_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic [$clog2(DEPTH)-1:0] raddr_i,
	output logic [WIDTH-1:0] rdata_o
);

	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		rdata_o <= mem_q[raddr_i];
	end

endmodule : status_hist_mem

//--- dv/flash_ctl_monitor.sv
module flash_ctl_monitor #(
	parameter int ADDR_W = 20
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [ADDR_W-1:0] addr_o,
	input wire logic [7:0] dq_o,
	input wire logic dq_oe_n_o,
	input wire logic ce_n_o,
	input wire logic oe_n_o,
	input wire logic we_n_o,
	input wire logic reset_powerdown_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence wr_pulse_s;
		!we_n_o [*2] ##1 we_n_o;
	endsequence
	sequence rd_pulse_s;
		!oe_n_o [*3] ##1 oe_n_o;
	endsequence
	bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a one cycle answer");
	write_pulse_a: assert property ($fell(we_n_o) |-> !$past(ce_n_o) ##0 wr_pulse_s)
		else $error("write strobe shape wrong");
	read_pulse_a: assert property ($fell(oe_n_o) |-> rd_pulse_s)
		else $error("read strobe shape wrong");
	reset_pulse_a: assert property ($fell(reset_powerdown_n_o) |-> !reset_powerdown_n_o [*3] ##1 reset_powerdown_n_o)
		else $error("reset pulse length wrong");
	reset_quiet_a: assert property (!reset_powerdown_n_o |-> ce_n_o && oe_n_o && we_n_o)
		else $error("strobe active during reset");
	write_drive_a: assert property (!we_n_o |-> !ce_n_o && !dq_oe_n_o && oe_n_o)
		else $error("write without select or data");
	read_release_a: assert property (!oe_n_o |-> !ce_n_o && dq_oe_n_o)
		else $error("read while driving data");
	data_hold_a: assert property (!we_n_o && !$past(we_n_o) |-> $stable(dq_o) && $stable(addr_o))
		else $error("data moved under write strobe");
	write_end_a: assert property ($rose(we_n_o) |-> ce_n_o && !dq_oe_n_o)
		else $error("data released at write end");
endmodule : flash_ctl_monitor

//--- dv/flash_dev_model.sv
module flash_dev_model (
	input wire logic clk_i,
	input wire logic ce_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic rp_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] dq_i,
	input wire logic [7:0] busy_len_i,
	input wire logic fail_i,
	input wire logic supply_i,
	input wire logic perm_i,
	output logic [7:0] dq_o,
	output logic rb_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] st_q = 8'h01, res_q = 8'h00, setup_q = 8'h00, bsy_q = 8'h00, last_q = 8'h00;
	logic stat_q = 1'b0, we_q = 1'b1, ce_q = 1'b1;
	logic [7:0] drv;
	// bit 7 shows ready, reads touch no flag
	assign drv = stat_q ? {bsy_q == 8'h00, st_q[6:0]} : addr_i ^ 8'h5a;
	// Released bus toggles so stale data never reads back
	assign dq_o = (!ce_n_i && !oe_n_i && rp_n_i) ? drv : ~last_q;
	// low while busy, else pulled up
	assign rb_n_o = bsy_q == 8'h00;
	always @(posedge clk_i) begin
		we_q <= we_n_i;
		ce_q <= ce_n_i;
		last_q <= dq_o;
		if (!rp_n_i) begin
			st_q <= 8'h01;
			stat_q <= 1'b0;
			setup_q <= 8'h00;
			res_q <= 8'h00;
			bsy_q <= {7'h00, bsy_q != 8'h00};
		end else if (bsy_q != 8'h00) begin
			bsy_q <= bsy_q - 8'h01;
			if (bsy_q == 8'h01)
				st_q <= st_q | res_q;
		end else if (we_n_i && !we_q && !ce_q) begin
			stat_q <= 1'b1;
			setup_q <= 8'h00;
			if (setup_q == 8'hc0 || setup_q == 8'h40) begin
				bsy_q <= busy_len_i;
				res_q <= {3'h0, fail_i | supply_i, supply_i, 3'h0};
			end else if (setup_q == 8'h60) begin
				bsy_q <= busy_len_i;
				res_q <= dq_i != 8'hd0 ? 8'h30 : perm_i ? 8'h22 : {2'h0, fail_i, 5'h00};
			end else if (dq_i == 8'hc0 || dq_i == 8'h60 || dq_i == 8'h40)
				setup_q <= dq_i;
			else if (dq_i == 8'hff)
				stat_q <= 1'b0;
			else if (dq_i == 8'h50)
				st_q <= 8'h01;
		end
	end
endmodule : flash_dev_model

//--- dv/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [2:0] op;
		logic [15:0] d;
		logic [2:0] flt;
		logic [7:0] st;
	} row_t;
	// Zero status means no poll: half of a hand-built sequence
	localparam row_t ROWS [12] = '{
		'{3'h6, 16'h003c, 3'h0, 8'h80}, '{3'h6, 16'h0055, 3'h4, 8'h90},
		'{3'h0, 16'h00c0, 3'h2, 8'h00}, '{3'h0, 16'h0066, 3'h2, 8'h98},
		'{3'h5, 16'h0050, 3'h0, 8'h80}, '{3'h2, 16'h60d0, 3'h1, 8'ha2},
		'{3'h5, 16'h0050, 3'h0, 8'h80}, '{3'h2, 16'h60d0, 3'h4, 8'ha0},
		'{3'h5, 16'h0050, 3'h0, 8'h80}, '{3'h2, 16'h6033, 3'h0, 8'hb0},
		'{3'h5, 16'h0050, 3'h0, 8'h80}, '{3'h2, 16'h4012, 3'h0, 8'h80}
	};
	logic clk_i = 1'b0, rst_i = 1'b1, wb_we = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0;
	logic fail = 1'b0, supply = 1'b0, perm = 1'b0;
	logic [7:0] wb_adr = 8'h00, blen = 8'h04;
	logic [31:0] wb_dat = 32'h0, rd;
	wire [31:0] wb_dat_o;
	wire [19:0] addr_o;
	wire [7:0] dq_o, dq_i;
	wire wb_ack_o, dq_oe_n_o, ce_n_o, oe_n_o, we_n_o, rp_n, wp_n_o, rb_n;
	int n_mismatch = 0, num_checks = 0, cyc_cnt = 0;
	always #25 clk_i = ~clk_i;
	flash_host_ctl dut_u (.clk_i, .rst_i, .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_dat_o, .wb_sel_i(4'hf),
		.wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_ack_o, .addr_o, .dq_o, .dq_i, .dq_oe_n_o,
		.ce_n_o, .oe_n_o, .we_n_o, .reset_powerdown_n_o(rp_n), .wp_n_o, .ready_busy_n_i(rb_n));
	flash_dev_model dev_u (.clk_i, .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .rp_n_i(rp_n),
		.addr_i(addr_o[7:0]), .dq_i(dq_oe_n_o ? ~dq_o : dq_o), .busy_len_i(blen), .fail_i(fail),
		.supply_i(supply), .perm_i(perm), .dq_o(dq_i), .rb_n_o(rb_n));
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		wb_adr <= a;
		wb_we <= w;
		wb_dat <= d;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic go(input logic [2:0] op, input logic [31:0] d);
		bus(flash_host_pkg::ADR_WDATA, 1'b1, d);
		bus(flash_host_pkg::ADR_CONTROL, 1'b1, {29'h7, op});
	endtask : go
	task automatic run_op(input logic [2:0] op, input logic [31:0] d);
		go(op, d);
		do bus(flash_host_pkg::ADR_STATUS, 1'b0, 32'h0); while (rd[8] !== 1'b0);
	endtask : run_op
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 40000) begin
			n_mismatch++;
			test_done();
		end
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check("wp_reset", 1'b1, wp_n_o);
		foreach (ROWS[i]) begin
			{fail, supply, perm} <= ROWS[i].flt;
			run_op(ROWS[i].op, {16'h0, ROWS[i].d});
			if (ROWS[i].st != 8'h00) begin
				run_op(flash_host_pkg::OP_POLL, 32'h0);
				check("status", ROWS[i].st, rd[7:0]);
				check("err_pend", |(ROWS[i].st & 8'h3a), rd[10]);
				check("seq_err", ROWS[i].st[5] & ROWS[i].st[4], rd[12]);
			end
		end
		// Long busy device, then reset mid-operation
		{fail, supply, perm} <= 3'h0;
		blen <= 8'd200;
		bus(flash_host_pkg::ADR_ADDRESS, 1'b1, 32'h0123);
		run_op(flash_host_pkg::OP_OTP, 32'h11);
		// Pin passes four flops (three synchroniser stages, then the filter) before it shows
		repeat (5) @(posedge clk_i);
		bus(flash_host_pkg::ADR_STATUS, 1'b0, 32'h0);
		check("rb_busy", 1'b0, rd[9]);
		run_op(flash_host_pkg::OP_RESET, 32'h0);
		check("aborted", 1'b1, rd[13]);
		run_op(flash_host_pkg::OP_READ, 32'h0);
		bus(flash_host_pkg::ADR_RDATA, 1'b0, 32'h0);
		check("array", 8'h79, rd[7:0]);
		run_op(flash_host_pkg::OP_POLL, 32'h0);
		check("status_clr", 8'h80, rd[7:0]);
		run_op(flash_host_pkg::OP_OTP, 32'h22);
		go(flash_host_pkg::OP_POLL, 32'h0);
		go(flash_host_pkg::OP_READ, 32'h0);
		run_op(flash_host_pkg::OP_POLL, 32'h0);
		check("busy_refused", 1'b1, rd[11]);
		bus(flash_host_pkg::ADR_CONTROL, 1'b1, 32'h90);
		bus(flash_host_pkg::ADR_STATUS, 1'b0, 32'h0);
		check("refused_clr", 1'b0, rd[11]);
		// Error pending blocks a new program
		blen <= 8'd4;
		fail <= 1'b1;
		run_op(flash_host_pkg::OP_OTP, 32'h33);
		run_op(flash_host_pkg::OP_POLL, 32'h0);
		run_op(flash_host_pkg::OP_OTP, 32'h44);
		check("pend_refused", 1'b1, rd[11]);
		run_op(flash_host_pkg::OP_CLEAR, 32'h50);
		bus(8'h40, 1'b0, 32'h0);
		check("unmapped", 32'h0, rd);
		bus(flash_host_pkg::ADR_CONTROL, 1'b1, 32'h0);
		check("wp_low", 1'b0, wp_n_o);
		// Controller reset mid-run; device keeps its state
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check("wp_rst", 1'b1, wp_n_o);
		bus(flash_host_pkg::ADR_STATUS, 1'b0, 32'h0);
		check("status_rst", 32'h200, rd);
		run_op(flash_host_pkg::OP_POLL, 32'h0);
		bus(flash_host_pkg::ADR_HIST, 1'b1, 32'h0);
		bus(flash_host_pkg::ADR_HIST, 1'b0, 32'h0);
		check("hist", 32'h280, rd);
		// Auto FFH after the poll leaves array reads
		run_op(flash_host_pkg::OP_READ, 32'h0);
		bus(flash_host_pkg::ADR_RDATA, 1'b0, 32'h0);
		check("array_ff", 8'h5a, rd[7:0]);
		test_done();
	end
endmodule : testbench
bind flash_host_ctl flash_ctl_monitor #(.ADDR_W(ADDR_W)) mon_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .addr_o, .dq_o, .dq_oe_n_o, .ce_n_o, .oe_n_o, .we_n_o, .reset_powerdown_n_o);
